// ===== core/ebi_external_bus.sv
// Function
// (RL1) in reset, data strobe low, address strobe toggles at clock over 32
// (RL2) after reset pin rises, fetch start vector, start after 67 cycles
// (RL3) low address muxed with data, high address byte on own port
// (RL4) optional program/data select output splits two 64K spaces
// (RL5) low address driven while address strobe low, held at its rise
// (RL6) read/write line low on writes, high on reads
// (RL7) write data valid on muxed lines by data strobe fall
// (RL8) external device gives read data before data strobe rise
// (RL9) data strobe low stretched by 0-7 waits, program and data separate
// (RL10) enabled external wait input stretches data strobe further
// (RL11) float bit releases both ports, both strobes and read/write
// (RL12) floated bus keeps core running; external accesses flagged
// (RL13) request and grant pins only act when enable bit set
// (RL14) request low at cycle start: stall cpu, float bus, grant low
// (RL15) request high again: pins driven within two clock cycles
// (RL16) external master drives bus only while granted or floated
// (RL17) waits count internal clock cycles; internal memory has no waits
// (RL18) halt and wfi: float muxed port, next opcode high, strobes high
//
// The address map and register access over Wishbone were decided locally.
`default_nettype none
module ebi_external_bus
	import ebi_pkg::*;
#(
	parameter int RST_DIV = OSC_DIV_RESET,
	parameter int BOOT_CYCLES = BOOT_OSC_CYCLES
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic coreReqValid,
	input wire ebiCoreReq_t coreReq,
	output logic coreReqReady,
	output logic coreRspValid,
	output logic [7:0] coreRspData,
	input wire logic cycleStart,
	input wire logic lowPower,
	input wire logic [15:0] nextOpAddr,
	output logic cpuStall,
	output logic startValid,
	output logic [15:0] startAddr,
	input wire logic resetPinN,
	input wire logic [7:0] muxedAddressDataIn,
	output logic [7:0] muxedAddressDataOut,
	output logic muxedAddressDataOe,
	output logic [7:0] highAddressByte,
	output logic highAddressByteOe,
	output logic addressStrobeN,
	output logic addressStrobeOe,
	output logic dataStrobeN,
	output logic dataStrobeOe,
	output logic readWriteN,
	output logic readWriteOe,
	output logic progDataSel,
	output logic progDataOe,
	input wire logic extWaitN,
	input wire logic busRequestN,
	output logic busGrantN,
	output logic busGrantOe
);
	localparam int DIV_W = $clog2(RST_DIV / 2);

	// ==========================================================
	// registers
	logic [MODE_W-1:0] modeReg_r;
	logic [7:0] waitReg_r;
	logic floatErr_r;
	logic wbAck_r;
	logic [31:0] wbDat_r;
	logic busFloatEnable;
	logic busRequestEnable;
	logic wbHit;
	logic wbWrite;
	ebiState_t state_r;
	ebiBoot_t boot_r;
	logic [BOOT_CNT_W-1:0] bootCnt_r;
	logic grant_r;

	assign busFloatEnable = modeReg_r[MODE_FLOAT_BIT];
	assign busRequestEnable = modeReg_r[MODE_BRQ_BIT];
	assign wbHit = wb_cyc_i && wb_stb_i;
	assign wbWrite = wbHit && wbAck_r && wb_we_i && wb_sel_i[0];

	always_ff @(posedge mclk) begin
		if (srst) begin
			wbAck_r <= 1'b0;
		end else begin
			wbAck_r <= wbHit && !wbAck_r;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			wbDat_r <= '0;
		end else if (wbHit && !wbAck_r) begin
			case (wb_adr_i[3:0])
				MODE_OFS: wbDat_r <= {28'h0000000, modeReg_r};
				WAIT_OFS: wbDat_r <= {24'h000000, waitReg_r};
				STAT_OFS: wbDat_r <= {startAddr, 12'h000, floatErr_r,
					boot_r == BT_RUN, state_r != ST_IDLE, grant_r};
				default: wbDat_r <= '0;
			endcase
		end
	end

	assign wb_ack_o = wbAck_r;
	assign wb_dat_o = wbDat_r;

	always_ff @(posedge mclk) begin
		if (srst) begin
			modeReg_r <= MODE_RESET;
		end else if (wbWrite && wb_adr_i[3:0] == MODE_OFS) begin
			modeReg_r <= wb_dat_i[MODE_W-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			waitReg_r <= WAIT_RESET;
		end else if (wbWrite && wb_adr_i[3:0] == WAIT_OFS) begin
			waitReg_r <= wb_dat_i[7:0];
		end
	end

	// ==========================================================
	// access acceptance
	logic grantTake;
	logic bootFetch;
	logic canStart;
	logic accept;
	logic [15:0] accAddr;
	logic [7:0] accData;
	logic accWrite;
	logic accProg;
	logic accBoot;
	logic [WAIT_W-1:0] accWait;
	logic extWaitActive;
	logic waitExpired;

	assign grantTake = busRequestEnable && cycleStart && !busRequestN
		&& state_r == ST_IDLE && !grant_r; // [RL14]
	assign bootFetch = boot_r == BT_FETCH0 || boot_r == BT_FETCH1;
	assign canStart = state_r == ST_IDLE && resetPinN && !grant_r && !grantTake
		&& !lowPower;
	assign coreReqReady = canStart && boot_r == BT_RUN;
	assign accept = canStart && (bootFetch || (boot_r == BT_RUN && coreReqValid));
	assign extWaitActive = modeReg_r[MODE_XWAIT_BIT] && !extWaitN;

	always_ff @(posedge mclk) begin
		if (srst) begin
			accAddr <= '0;
			accData <= '0;
			accWrite <= 1'b0;
			accProg <= 1'b1;
			accBoot <= 1'b0;
			accWait <= '0;
		end else if (accept) begin
			accBoot <= bootFetch;
			accAddr <= bootFetch ? (boot_r == BT_FETCH0 ? BOOT_VEC_HI : BOOT_VEC_LO)
				: coreReq.addr;
			accData <= coreReq.wdata;
			accWrite <= !bootFetch && coreReq.write;
			accProg <= bootFetch || coreReq.progSpace;
			// separate counts for program and data space
			accWait <= (bootFetch || coreReq.progSpace) ? // [RL9]
				waitReg_r[PWAIT_LSB +: WAIT_W] : waitReg_r[DWAIT_LSB +: WAIT_W];
		end
	end

	// accepted while floated: cycle runs with pins released
	always_ff @(posedge mclk) begin
		if (srst) begin
			floatErr_r <= 1'b0;
		end else if (accept && busFloatEnable) begin // [RL12]
			floatErr_r <= 1'b1;
		end else if (wbWrite && wb_adr_i[3:0] == STAT_OFS && wb_dat_i[STAT_FERR_BIT]) begin
			floatErr_r <= 1'b0;
		end
	end

	// only external cycles reach the timer
	ebi_wait_timer #(
		.WIDTH(WAIT_W)
	) waitTimer (
		.mclk(mclk),
		.srst(srst),
		.load(state_r == ST_SETUP), // [RL17]
		.loadValue(accWait),
		.extWait(extWaitActive),
		.expired(waitExpired)
	);

	// ==========================================================
	// bus cycle sequencer
	always_ff @(posedge mclk) begin
		if (srst || !resetPinN) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: state_r <= accept ? ST_ADDR : ST_IDLE;
				ST_ADDR: state_r <= ST_LATCH;
				ST_LATCH: state_r <= ST_SETUP;
				ST_SETUP: state_r <= ST_DATA;
				ST_DATA: state_r <= waitExpired ? ST_END : ST_DATA; // [RL9] [RL10]
				ST_END: state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// read data sampled at the edge where the strobe rises
	always_ff @(posedge mclk) begin
		if (srst) begin
			coreRspValid <= 1'b0;
			coreRspData <= '0;
		end else begin
			coreRspValid <= state_r == ST_END && !accBoot && resetPinN;
			if (state_r == ST_END && !accWrite) begin // [RL8]
				coreRspData <= muxedAddressDataIn;
			end
		end
	end

	// ==========================================================
	// start vector and start delay
	always_ff @(posedge mclk) begin
		if (srst || !resetPinN) begin
			boot_r <= BT_HOLD;
			bootCnt_r <= '0;
		end else begin
			if (bootCnt_r != BOOT_CNT_W'(BOOT_CYCLES)) begin
				bootCnt_r <= BOOT_CNT_W'(bootCnt_r + 1'b1);
			end
			case (boot_r)
				BT_HOLD: boot_r <= BT_FETCH0;
				BT_FETCH0: boot_r <= (state_r == ST_END) ? BT_FETCH1 : BT_FETCH0;
				BT_FETCH1: boot_r <= (state_r == ST_END) ? BT_COUNT : BT_FETCH1;
				BT_COUNT: boot_r <= (bootCnt_r >= BOOT_CNT_W'(BOOT_CYCLES - 1)) ? // [RL2]
					BT_RUN : BT_COUNT;
				BT_RUN: boot_r <= BT_RUN;
				default: boot_r <= BT_HOLD;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			startAddr <= '0;
		end else if (state_r == ST_END && accBoot) begin // [RL2]
			if (boot_r == BT_FETCH0) begin
				startAddr[15:8] <= muxedAddressDataIn;
			end else begin
				startAddr[7:0] <= muxedAddressDataIn;
			end
		end
	end

	assign startValid = boot_r == BT_RUN;

	// ==========================================================
	// bus request and grant
	always_ff @(posedge mclk) begin
		if (srst || !busRequestEnable) begin // [RL13]
			grant_r <= 1'b0;
		end else if (grantTake) begin // [RL14]
			grant_r <= 1'b1;
		end else if (grant_r && busRequestN) begin // [RL15] [RL16]
			grant_r <= 1'b0;
		end
	end

	assign cpuStall = grant_r; // [RL14]
	assign busGrantN = !grant_r;
	assign busGrantOe = busRequestEnable; // [RL13]

	// ==========================================================
	// reset strobe divider
	logic [DIV_W-1:0] divCnt_r;
	logic asDiv_r;

	always_ff @(posedge mclk) begin // [RL1]
		if (srst) begin
			divCnt_r <= '0;
			asDiv_r <= 1'b0;
		end else begin
			divCnt_r <= DIV_W'(divCnt_r + 1'b1);
			if (divCnt_r == DIV_W'(RST_DIV / 2 - 1)) begin
				asDiv_r <= !asDiv_r;
			end
		end
	end

	// ==========================================================
	// pin drive
	ebiPins_t pins_r;
	ebiPins_t pins_nxt;
	logic floatNow;

	assign floatNow = busFloatEnable || grant_r;

	always_comb begin
		pins_nxt.adOut = accAddr[7:0];
		pins_nxt.adOe = 1'b0;
		pins_nxt.hiAddr = accAddr[15:8]; // [RL3]
		pins_nxt.hiOe = 1'b1;
		pins_nxt.asN = 1'b1;
		pins_nxt.dsN = 1'b1;
		pins_nxt.rwN = 1'b1;
		pins_nxt.ctlOe = 1'b1;
		pins_nxt.pdSel = accProg; // [RL4]
		pins_nxt.pdOe = modeReg_r[MODE_PD_BIT];
		case (state_r)
			ST_ADDR: begin
				pins_nxt.asN = 1'b0; // [RL5]
				pins_nxt.adOe = 1'b1;
				pins_nxt.rwN = !accWrite;
			end
			ST_LATCH: begin
				pins_nxt.adOe = 1'b1; // [RL5]
				pins_nxt.rwN = !accWrite;
			end
			ST_SETUP, ST_END: begin
				pins_nxt.adOut = accData;
				pins_nxt.adOe = accWrite;
				pins_nxt.rwN = !accWrite; // [RL6]
			end
			ST_DATA: begin
				pins_nxt.adOut = accData; // [RL7]
				pins_nxt.adOe = accWrite;
				pins_nxt.dsN = 1'b0;
				pins_nxt.rwN = !accWrite; // [RL6]
			end
			default: begin
				pins_nxt.adOe = 1'b0;
			end
		endcase
		if (lowPower && state_r == ST_IDLE) begin // [RL18]
			pins_nxt.hiAddr = nextOpAddr[15:8];
			pins_nxt.adOe = 1'b0;
		end
		if (floatNow) begin // [RL11] [RL14]
			pins_nxt.adOe = 1'b0;
			pins_nxt.hiOe = 1'b0;
			pins_nxt.ctlOe = 1'b0;
			pins_nxt.pdOe = 1'b0;
		end
		if (!resetPinN) begin // [RL1]
			pins_nxt.asN = asDiv_r;
			pins_nxt.dsN = 1'b0;
			pins_nxt.rwN = 1'b1;
			pins_nxt.adOe = 1'b0;
			pins_nxt.ctlOe = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			pins_r <= '{adOut: 8'h00, adOe: 1'b0, hiAddr: 8'h00, hiOe: 1'b0,
				asN: 1'b1, dsN: 1'b1, rwN: 1'b1, ctlOe: 1'b0, pdSel: 1'b1, pdOe: 1'b0};
		end else begin
			pins_r <= pins_nxt;
		end
	end

	assign muxedAddressDataOut = pins_r.adOut;
	assign muxedAddressDataOe = pins_r.adOe;
	assign highAddressByte = pins_r.hiAddr;
	assign highAddressByteOe = pins_r.hiOe;
	assign addressStrobeN = pins_r.asN;
	assign addressStrobeOe = pins_r.ctlOe;
	assign dataStrobeN = pins_r.dsN;
	assign dataStrobeOe = pins_r.ctlOe;
	assign readWriteN = pins_r.rwN;
	assign readWriteOe = pins_r.ctlOe;
	assign progDataSel = pins_r.pdSel;
	assign progDataOe = pins_r.pdOe;

	// ==========================================================
	// checks
	logic [3:0] dataCnt_r;
	logic extSeen_r;
	logic seenFall_r;

	always_ff @(posedge mclk) begin
		if (srst || state_r != ST_DATA) begin
			dataCnt_r <= '0;
			extSeen_r <= 1'b0;
		end else begin
			dataCnt_r <= 4'(dataCnt_r + 1'b1);
			extSeen_r <= extSeen_r || extWaitActive;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			seenFall_r <= 1'b0;
		end else if (asDiv_r && divCnt_r == DIV_W'(RST_DIV / 2 - 1)) begin
			seenFall_r <= 1'b1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	resetDsLow_a: assert property ((!resetPinN ##1 !resetPinN) |=> // [RL1]
		!dataStrobeN && dataStrobeOe && addressStrobeN == $past(asDiv_r))
		else $error("strobes wrong during reset");
	asPeriod_a: assert property (($rose(asDiv_r) && seenFall_r) |-> // [RL1]
		$past(asDiv_r, RST_DIV / 2) == 1'b0 && $past(asDiv_r, RST_DIV / 2 + 1) == 1'b1)
		else $error("reset strobe period wrong");
	bootStart_a: assert property ($rose(startValid) |-> // [RL2]
		bootCnt_r == BOOT_CNT_W'(BOOT_CYCLES))
		else $error("start not at boot count");
	highAddr_a: assert property ((state_r == ST_ADDR && resetPinN && !floatNow) |=> // [RL3]
		highAddressByte == accAddr[15:8] && highAddressByteOe && progDataSel == accProg)
		else $error("high address or space select wrong");
	addrHold_a: assert property (($rose(addressStrobeN) && muxedAddressDataOe) |-> // [RL5]
		$stable(muxedAddressDataOut) && muxedAddressDataOut == accAddr[7:0])
		else $error("address not held at strobe rise");
	readDir_a: assert property ((state_r == ST_DATA && !accWrite && resetPinN) |=> // [RL6]
		readWriteN && !muxedAddressDataOe)
		else $error("read direction wrong");
	writeData_a: assert property ((state_r == ST_DATA && accWrite && resetPinN // [RL7]
		&& !floatNow) |=> !readWriteN && muxedAddressDataOe && muxedAddressDataOut == accData)
		else $error("write data not on bus");
	waitLen_a: assert property ((state_r == ST_DATA && waitExpired && !extSeen_r // [RL9]
		&& !extWaitActive) |-> dataCnt_r == 4'(accWait))
		else $error("wait count wrong");
	extWait_a: assert property ((state_r == ST_DATA && extWaitActive && resetPinN) |=> // [RL10]
		state_r == ST_DATA)
		else $error("external wait ignored");
	floatPins_a: assert property ((busFloatEnable && resetPinN) |=> // [RL11]
		!addressStrobeOe && !muxedAddressDataOe && !highAddressByteOe && !dataStrobeOe)
		else $error("bus not floated");
	floatFlag_a: assert property ((accept && busFloatEnable) |=> floatErr_r) // [RL12]
		else $error("floated access not flagged");
	brqOff_a: assert property (!busRequestEnable |=> !grant_r && busGrantN) // [RL13]
		else $error("grant while disabled");
	grantTake_a: assert property ((grantTake && resetPinN) |=> // [RL14]
		!busGrantN && cpuStall ##1 (!addressStrobeOe || !$past(resetPinN)))
		else $error("grant not given");
	grantFree_a: assert property ((grant_r && busRequestN && busRequestEnable) ##1 // [RL15]
		!busFloatEnable |=> addressStrobeOe)
		else $error("pins not driven after release");
	lowPower_a: assert property ((lowPower && state_r == ST_IDLE && resetPinN) |=> // [RL18]
		!muxedAddressDataOe && addressStrobeN && dataStrobeN && readWriteN
		&& highAddressByte == $past(nextOpAddr[15:8]))
		else $error("low power pins wrong");

	grantSeen_c: cover property (grantTake ##1 grant_r ##[1:20] !grant_r);
	waitRead_c: cover property (state_r == ST_DATA && !accWrite && accWait != '0
		##1 state_r == ST_END);
	bootDone_c: cover property ($rose(startValid));
	extStretch_c: cover property (state_r == ST_DATA && extWaitActive);
endmodule
`default_nettype wire

// ===== core/ebi_pkg.sv
`default_nettype none
package ebi_pkg;
	// ==========================================================
	// timing
	localparam int OSC_DIV_RESET = 32;
	localparam int BOOT_OSC_CYCLES = 67;
	localparam int BOOT_CNT_W = 7;
	localparam int WAIT_W = 3;
	// ==========================================================
	// register offsets
	localparam logic [3:0] MODE_OFS = 4'h0;
	localparam logic [3:0] WAIT_OFS = 4'h4;
	localparam logic [3:0] STAT_OFS = 4'h8;
	// ==========================================================
	// mode_control_register fields
	localparam int MODE_W = 4;
	localparam int MODE_FLOAT_BIT = 0;
	localparam int MODE_BRQ_BIT = 1;
	localparam int MODE_PD_BIT = 2;
	localparam int MODE_XWAIT_BIT = 3;
	localparam logic [3:0] MODE_RESET = 4'h0;
	// ==========================================================
	// wait_control_register fields
	localparam int PWAIT_LSB = 0;
	localparam int DWAIT_LSB = 4;
	localparam logic [7:0] WAIT_RESET = 8'h77;
	// ==========================================================
	// status fields
	localparam int STAT_GRANT_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_BOOT_BIT = 2;
	localparam int STAT_FERR_BIT = 3;
	localparam int STAT_START_LSB = 16;
	// ==========================================================
	// start vector locations in program space
	localparam logic [15:0] BOOT_VEC_HI = 16'h0000;
	localparam logic [15:0] BOOT_VEC_LO = 16'h0001;
	// ==========================================================
	// types
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic write;
		logic progSpace;
	} ebiCoreReq_t;

	typedef struct packed {
		logic [7:0] adOut;
		logic adOe;
		logic [7:0] hiAddr;
		logic hiOe;
		logic asN;
		logic dsN;
		logic rwN;
		logic ctlOe;
		logic pdSel;
		logic pdOe;
	} ebiPins_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_LATCH = 3'b010,
		ST_SETUP = 3'b011,
		ST_DATA = 3'b100,
		ST_END = 3'b101
	} ebiState_t;

	typedef enum logic [2:0] {
		BT_HOLD = 3'b000,
		BT_FETCH0 = 3'b001,
		BT_FETCH1 = 3'b010,
		BT_COUNT = 3'b011,
		BT_RUN = 3'b100
	} ebiBoot_t;
endpackage
`default_nettype wire

// ===== core/ebi_wait_timer.sv
`default_nettype none
module ebi_wait_timer
	import ebi_pkg::*;
#(
	parameter int WIDTH = WAIT_W
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic load,
	input wire logic [WIDTH-1:0] loadValue,
	input wire logic extWait,
	output logic expired
);
	logic [WIDTH-1:0] cnt_r;

	// counts mclk cycles, the internal clock, not cpu clock
	always_ff @(posedge mclk) begin // [RL17]
		if (srst) begin
			cnt_r <= '0;
		end else if (load) begin
			cnt_r <= loadValue;
		end else if (cnt_r != '0) begin
			cnt_r <= WIDTH'(cnt_r - 1'b1);
		end
	end

	// external wait holds the strobe low past the programmed count
	assign expired = (cnt_r == '0) && !extWait; // [RL9] [RL10]
endmodule
`default_nettype wire

// ===== tb/ebi_external_bus_test.sv
`default_nettype none
module ebi_external_bus_test
	import ebi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// signals
	localparam int RDIV = 8;
	localparam int BOOT = 20;
	logic mclk = 1'b0, srst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
	logic [31:0] wbAdr = 32'h0, wbDat = 32'h0, wbDatO;
	logic reqValid = 1'b0, coreReqReady, coreRspValid, cycleStart = 1'b0, lowPower = 1'b0;
	ebiCoreReq_t coreReq = '0;
	logic [7:0] coreRspData, adOut, adIn, hiAddr;
	logic [15:0] nextOp = 16'h0, startAddr, mAddr;
	logic cpuStall, startValid, resetPinN = 1'b1, adOe, hiOe, asN, asOe, dsN, dsOe, rwN, rwOe;
	logic pdSel, pdOe, extWaitN, busReqN = 1'b1, busGrantN, busGrantOe, mRwN, mPd, pdEn = 1'b0;
	logic [3:0] waitLen = 4'h0;
	logic [7:0] mdl [int];
	int errTotal = 0, cmpCount = 0, cycles = 0;
	ebi_external_bus #(.RST_DIV(RDIV), .BOOT_CYCLES(BOOT)) dut (.mclk(mclk), .srst(srst),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(4'hf), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
		.coreReqValid(reqValid), .coreReq(coreReq), .coreReqReady(coreReqReady),
		.coreRspValid(coreRspValid), .coreRspData(coreRspData), .cycleStart(cycleStart),
		.lowPower(lowPower), .nextOpAddr(nextOp), .cpuStall(cpuStall),
		.startValid(startValid), .startAddr(startAddr), .resetPinN(resetPinN),
		.muxedAddressDataIn(adIn), .muxedAddressDataOut(adOut), .muxedAddressDataOe(adOe),
		.highAddressByte(hiAddr), .highAddressByteOe(hiOe), .addressStrobeN(asN),
		.addressStrobeOe(asOe), .dataStrobeN(dsN), .dataStrobeOe(dsOe), .readWriteN(rwN),
		.readWriteOe(rwOe), .progDataSel(pdSel), .progDataOe(pdOe), .extWaitN(extWaitN),
		.busRequestN(busReqN), .busGrantN(busGrantN), .busGrantOe(busGrantOe));
	ebi_mem_model uMem (.mclk(mclk), .adOut(adOut), .adOe(adOe), .hiAddr(hiAddr),
		.asN(asN), .dsN(dsN), .rwN(rwN), .ctlOe(asOe), .pdSel(pdSel), .pdOe(pdOe),
		.waitLen(waitLen), .adIn(adIn), .extWaitN(extWaitN), .lastAddr(mAddr),
		.lastRwN(mRwN), .lastPd(mPd));
	initial begin
		forever #5 mclk = ~mclk;
	end
	// ==========================================================
	// shared tasks
	task automatic giveVerdict();
		$display("Comparisons %0d, mismatches %0d", cmpCount, errTotal);
		if (errTotal == 0 && cmpCount > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			errTotal++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] mval(input int k);
		return mdl.exists(k) ? mdl[k] : (k[7:0] ^ k[15:8] ^ 8'h5a);
	endfunction
	task automatic wb(input logic we, input logic [3:0] ofs, input logic [31:0] d,
		output logic [31:0] q);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= {28'h0, ofs};
		wbDat <= d;
		@(posedge mclk);
		while (wbAck !== 1'b1) begin
			@(posedge mclk);
		end
		q = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic core(input logic wr, input logic ps, input logic [15:0] a,
		input logic [7:0] wd, output logic [7:0] rd, output int lat);
		lat = 0;
		reqValid <= 1'b1;
		coreReq <= {a, wd, wr, ps};
		@(posedge mclk);
		while (coreReqReady !== 1'b1) begin
			@(posedge mclk);
		end
		reqValid <= 1'b0;
		@(posedge mclk);
		lat = 1;
		while (coreRspValid !== 1'b1 && lat < 200) begin
			@(posedge mclk);
			lat++;
		end
		rd = coreRspData;
	endtask
	task automatic acc(input logic wr, input logic ps, input logic [15:0] a, input int w,
		input int e);
		logic [7:0] rd, wd;
		int lat, k;
		wd = 8'($urandom);
		k = {15'h0, ps | !pdEn, a};
		core(wr, ps, a, wd, rd, lat);
		chk(mAddr, a);
		chk(mRwN, !wr);
		chk(mPd, k[16]);
		if (e == 0) chk(lat, 6 + w);
		else chk(lat >= 7 + w && lat <= 7 + w + e, 1);
		if (wr) mdl[k] = wd;
		else chk(rd, mval(k));
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			errTotal++;
			$display("Error at %0t: run did not finish", $time);
			giveVerdict();
		end
	end
	// ==========================================================
	// scenarios
	initial begin
		logic [31:0] q;
		logic [15:0] a, sv;
		logic [7:0] r;
		logic ps;
		int pw, dw, n;
		n = $urandom(32'h33f5dd44);
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		for (int pass = 0; pass < 2; pass++) begin
			n = 0;
			while (startValid !== 1'b1 && n < 500) begin
				@(negedge mclk);
				n++;
			end
			@(posedge mclk);
			chk(n >= BOOT, 1);
			sv = {mval(32'h10000), mval(32'h10001)};
			chk(startAddr, sv);
			if (pass == 1) break;
			wb(0, MODE_OFS, 0, q);
			chk(q, 0);
			wb(0, WAIT_OFS, 0, q);
			chk(q, 32'h77);
			wb(0, 4'hc, 0, q);
			chk(q, 0);
			wb(1, MODE_OFS, 32'h4, q);
			pdEn = 1'b1;
			for (int i = 0; i < 10; i++) begin
				pw = $urandom_range(7);
				dw = $urandom_range(7);
				if (i < 2) pw = 7 * i;
				if (i < 2) dw = 7 - pw;
				wb(1, WAIT_OFS, 32'(dw * 16 + pw), q);
				a = 16'($urandom);
				ps = 1'($urandom);
				acc(1, ps, a, ps ? pw : dw, 0);
				acc(0, ps, a, ps ? pw : dw, 0);
				acc(0, !ps, a, ps ? dw : pw, 0);
			end
			wb(1, WAIT_OFS, 0, q);
			waitLen <= 4'h4;
			acc(0, 1, 16'h1234, 0, 0);
			wb(1, MODE_OFS, 32'hc, q);
			acc(0, 1, 16'h1234, 0, 4);
			waitLen <= 4'h0;
			wb(1, MODE_OFS, 32'h1, q);
			@(negedge mclk);
			chk({adOe, hiOe, asOe, dsOe, rwOe}, 0);
			@(posedge mclk);
			core(1, 1, 16'h0100, 8'h99, r, n);
			wb(0, STAT_OFS, 0, q);
			chk(q, {sv, 16'h000c});
			wb(1, STAT_OFS, 32'h8, q);
			wb(0, STAT_OFS, 0, q);
			chk(q[STAT_FERR_BIT], 0);
			for (int en = 0; en < 2; en++) begin
				wb(1, MODE_OFS, 32'(2 * en), q);
				pdEn = 1'b0;
				@(negedge mclk);
				chk(asOe, 1);
				@(posedge mclk);
				busReqN <= 1'b0;
				cycleStart <= 1'b1;
				@(posedge mclk);
				cycleStart <= 1'b0;
				repeat (3) @(negedge mclk);
				if (en == 0) chk({busGrantN, busGrantOe}, 2'b10);
				else chk({busGrantN, cpuStall, asOe, hiOe, coreReqReady}, 5'b01000);
				@(posedge mclk);
				busReqN <= 1'b1;
				repeat (4) @(negedge mclk);
				chk({busGrantN, cpuStall, asOe, hiOe}, 4'b1011);
				@(posedge mclk);
			end
			a = 16'($urandom);
			nextOp <= a;
			lowPower <= 1'b1;
			repeat (3) @(negedge mclk);
			chk({adOe, hiAddr, asN, dsN, rwN, coreReqReady}, {1'b0, a[15:8], 4'b1110});
			@(posedge mclk);
			lowPower <= 1'b0;
			resetPinN <= 1'b0;
			repeat (4) @(negedge mclk);
			ps = asN;
			n = 0;
			pw = 0;
			for (int i = 0; i < 4 * RDIV; i++) begin
				@(negedge mclk);
				n++;
				chk({dsN, dsOe, startValid}, 3'b010);
				if (asN !== ps) begin
					if (pw > 0) chk(n, RDIV / 2);
					pw++;
					n = 0;
					ps = asN;
				end
			end
			chk(pw >= 6, 1);
			@(posedge mclk);
			resetPinN <= 1'b1;
		end
		giveVerdict();
	end
endmodule
`default_nettype wire

// ===== tb/ebi_mem_model.sv
`default_nettype none
module ebi_mem_model
	import ebi_pkg::*;
(
	input wire logic mclk,
	input wire logic [7:0] adOut,
	input wire logic adOe,
	input wire logic [7:0] hiAddr,
	input wire logic asN,
	input wire logic dsN,
	input wire logic rwN,
	input wire logic ctlOe,
	input wire logic pdSel,
	input wire logic pdOe,
	input wire logic [3:0] waitLen,
	output logic [7:0] adIn,
	output logic extWaitN,
	output logic [15:0] lastAddr,
	output logic lastRwN,
	output logic lastPd
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// memory and latch
	logic [7:0] mem [0:131071];
	logic [7:0] lastBus = 8'h00;
	logic [15:0] addr_r = 16'h0000;
	logic space_r = 1'b1;
	logic rw_r = 1'b1;
	logic dsPrev = 1'b1;
	int cnt = 15;
	initial begin
		for (int i = 0; i < 131072; i++) begin
			mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
		end
	end
	// own output echoed while driven; read data only while strobe low and bus free; otherwise a changing pattern
	assign adIn = adOe ? adOut :
		(ctlOe && !dsN && rwN) ? mem[{space_r, addr_r}] : ~lastBus;
	assign extWaitN = !(cnt >= 1 && cnt <= 32'(waitLen));
	assign lastAddr = addr_r;
	assign lastRwN = rw_r;
	assign lastPd = space_r;
	always @(posedge mclk) begin
		lastBus <= adIn;
		if (ctlOe && !asN) begin
			addr_r <= {hiAddr, adOut};
			space_r <= pdOe ? pdSel : 1'b1;
			cnt <= 0;
		end else if (cnt < 15) begin
			cnt <= cnt + 1;
		end
		if (ctlOe && !dsN && dsPrev) begin
			rw_r <= rwN;
		end
		dsPrev <= dsN | !ctlOe;
		if (ctlOe && !dsN && !rwN && adOe) begin
			mem[{space_r, addr_r}] <= adOut;
		end
	end
endmodule
`default_nettype wire
